// ==== core/ard_measure.sv ====
// auto-rate measurement engine for the serial rate generator
`timescale 1ns/1ns
`default_nettype none
`include "ard_regs.svh"
module ard_measure
   import ard_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // serial line
   input wire logic rx_in,
   // configuration
   input wire logic async_mode,
   input wire logic wake_on_rx_enable,
   input wire ard_clk_cfg_type clk_cfg,
   // software strobes
   input wire logic measure_enable_set,
   input wire logic measure_enable_clear,
   input wire logic rollover_set,
   input wire logic rollover_clear,
   input wire logic divisor_write,
   input wire ard_divisor_type divisor_wdata,
   input wire logic wake_break_done,
   input wire logic rx_holding_read,
   // status
   output logic rate_measure_enable,
   output logic measure_rollover_flag,
   output logic rx_ready_flag,
   output logic rx_hold_idle,
   output logic rate_timer_reset,
   output ard_divisor_type divisor
);
   ard_state_type state;
   ard_state_type next_state;
   logic [`ARD_PRE_W-1:0] prescale;
   logic [`ARD_EDGE_W-1:0] edge_count;
   logic rx_prev;
   logic break_seen;
   wire logic rx_level;

   ard_rx_filter u_filter (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .rx_in(rx_in),
      .rx_level(rx_level)
   );

   function automatic logic [`ARD_PRE_W-1:0] tick_limit(input ard_clk_cfg_type c);
      unique case ({c.wide_divisor_select, c.high_speed_select})
         2'h0: tick_limit = `ARD_PRE_512;
         2'h3: tick_limit = `ARD_PRE_32;
         default: tick_limit = `ARD_PRE_128;
      endcase
   endfunction

   // allowed only in async, and with wake enabled only after the break
   wire logic allowed = async_mode & (~wake_on_rx_enable | break_seen);
   wire logic rx_rise = rx_level & ~rx_prev;
   wire logic rx_fall = ~rx_level & rx_prev;
   // tick = one eighth of the normal generator clock
   wire logic tick = (prescale == tick_limit(clk_cfg));
   wire logic counting = (state == ARD_COUNT);
   wire logic last_edge = counting & rx_rise & (edge_count == `ARD_EDGE_LAST - `ARD_EDGE_FIRST);
   wire logic wrap = counting & tick & (divisor == `ARD_DIV_MAX) & ~last_edge;
   wire logic measuring = (state != ARD_IDLE);

   always_comb begin
      next_state = state;
      unique case (state)
         ARD_IDLE: if (rate_measure_enable && allowed) next_state = ARD_WAIT_START;
         ARD_WAIT_START: if (rx_fall) next_state = ARD_WAIT_RISE;
         ARD_WAIT_RISE: if (rx_rise) next_state = ARD_COUNT;
         ARD_COUNT: if (last_edge) next_state = ARD_IDLE;
         default: next_state = ARD_IDLE;
      endcase
      if (!rate_measure_enable) next_state = ARD_IDLE;
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state <= ARD_IDLE;
         prescale <= `ARD_PRE_ZERO;
         edge_count <= `ARD_EDGE_W'(0);
         rx_prev <= 1'h1;
         break_seen <= 1'h0;
      end else if (clk_en) begin
         state <= next_state;
         rx_prev <= rx_level;
         if (wake_break_done) break_seen <= 1'h1;
         else if (!rate_measure_enable) break_seen <= 1'h0;
         prescale <= (!counting || tick) ? `ARD_PRE_ZERO : prescale + 1'b1;
         // the first rise is counted on entry, so the fifth arrives at a count of four
         if (state == ARD_WAIT_RISE) edge_count <= `ARD_EDGE_FIRST;
         else if (counting && rx_rise) edge_count <= edge_count + 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         divisor <= ard_divisor_type'(`ARD_DIV_ZERO);
         rate_measure_enable <= 1'h0;
         measure_rollover_flag <= 1'h0;
         rx_ready_flag <= 1'h0;
         rx_hold_idle <= 1'h0;
         rate_timer_reset <= 1'h0;
      end else if (clk_en) begin
         rx_hold_idle <= measuring;
         rate_timer_reset <= divisor_write;
         if (last_edge) rate_measure_enable <= 1'h0;
         else if (measure_enable_set) rate_measure_enable <= 1'h1;
         else if (measure_enable_clear) rate_measure_enable <= 1'h0;
         // hardware set wins over software clear
         if (wrap || rollover_set) measure_rollover_flag <= 1'h1;
         else if (rollover_clear) measure_rollover_flag <= 1'h0;
         if (last_edge) rx_ready_flag <= 1'h1;
         else if (rx_holding_read) rx_ready_flag <= 1'h0;
         if (state == ARD_IDLE && rate_measure_enable && allowed)
            divisor <= ard_divisor_type'(`ARD_DIV_ZERO);
         else if (counting && tick && !last_edge)
            divisor <= divisor + 1'b1;
         else if (!measuring && divisor_write)
            divisor <= divisor_wdata;
      end
   end

   // steps of a measurement, shared by the properties below
   sequence s_arm;
      clk_en && state == ARD_IDLE && next_state == ARD_WAIT_START;
   endsequence
   sequence s_wrap;
      clk_en && wrap && !measure_enable_clear;
   endsequence
   sequence s_fifth;
      clk_en && last_edge;
   endsequence

   property p_rollover;
      @(posedge sys_clk) disable iff (sys_rst)
      s_wrap |=> measure_rollover_flag && rate_measure_enable;
   endproperty
   a_rollover: assert property (p_rollover) else $error("rollover not flagged");
   property p_wrap;
      @(posedge sys_clk) disable iff (sys_rst)
      s_wrap |=> divisor == `ARD_DIV_ZERO;
   endproperty
   a_wrap: assert property (p_wrap) else $error("divisor did not wrap");
   property p_last_edge;
      @(posedge sys_clk) disable iff (sys_rst)
      s_fifth |=> !rate_measure_enable && rx_ready_flag && state == ARD_IDLE;
   endproperty
   a_last_edge: assert property (p_last_edge) else $error("fifth edge not handled");
   property p_step;
      @(posedge sys_clk) disable iff (sys_rst)
      clk_en && counting && !last_edge |=> divisor == $past(divisor) + (($past(tick)) ? 16'h0001 : 16'h0000);
   endproperty
   a_step: assert property (p_step) else $error("counter step wrong");
   property p_idle_hold;
      @(posedge sys_clk) disable iff (sys_rst)
      clk_en && measuring |=> rx_hold_idle;
   endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("receiver not held idle");
   property p_gate;
      @(posedge sys_clk) disable iff (sys_rst)
      clk_en && state == ARD_IDLE && !async_mode |=> state == ARD_IDLE;
   endproperty
   a_gate: assert property (p_gate) else $error("measure in sync mode");
   property p_timer;
      @(posedge sys_clk) disable iff (sys_rst)
      clk_en && divisor_write |=> rate_timer_reset;
   endproperty
   a_timer: assert property (p_timer) else $error("timer not reset");
   property p_clear_start;
      @(posedge sys_clk) disable iff (sys_rst)
      s_arm |=> divisor == `ARD_DIV_ZERO;
   endproperty
   a_clear_start: assert property (p_clear_start) else $error("counter not cleared");

   property p_start;
      @(posedge sys_clk) disable iff (sys_rst)
      clk_en && state == ARD_WAIT_START && rx_fall && rate_measure_enable |=> state == ARD_WAIT_RISE;
   endproperty
   a_start: assert property (p_start) else $error("start bit missed");
   property p_first_rise;
      @(posedge sys_clk) disable iff (sys_rst)
      clk_en && state == ARD_WAIT_RISE && rx_rise && rate_measure_enable
      |=> counting && divisor == $past(divisor);
   endproperty
   a_first_rise: assert property (p_first_rise) else $error("count did not start");
   property p_enable_hold;
      @(posedge sys_clk) disable iff (sys_rst)
      clk_en && counting && rate_measure_enable && !last_edge && !measure_enable_clear |=> rate_measure_enable;
   endproperty
   a_enable_hold: assert property (p_enable_hold) else $error("enable dropped early");
   property p_sw_clear;
      @(posedge sys_clk) disable iff (sys_rst)
      clk_en && rollover_clear && !rollover_set && !wrap |=> !measure_rollover_flag;
   endproperty
   a_sw_clear: assert property (p_sw_clear) else $error("rollover not cleared");
   property p_read_clear;
      @(posedge sys_clk) disable iff (sys_rst)
      clk_en && rx_holding_read && !last_edge |=> !rx_ready_flag;
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("ready not cleared by read");
   property p_wait_hold;
      @(posedge sys_clk) disable iff (sys_rst)
      clk_en && (state == ARD_WAIT_START || state == ARD_WAIT_RISE) |=> $stable(divisor);
   endproperty
   a_wait_hold: assert property (p_wait_hold) else $error("divisor moved before count");
endmodule
`default_nettype wire

// ==== common/ard_regs.svh ====
// constants for the auto-rate measurement block
`ifndef ARD_REGS_SVH
`define ARD_REGS_SVH
`define ARD_DIV_W 16
`define ARD_DIV_ZERO 16'h0000
`define ARD_DIV_MAX 16'hFFFF
`define ARD_EDGE_W 3
`define ARD_EDGE_FIRST 3'h1
`define ARD_EDGE_LAST 3'h5
`define ARD_PRE_W 9
`define ARD_PRE_512 9'h1FF
`define ARD_PRE_128 9'h07F
`define ARD_PRE_32 9'h01F
`define ARD_PRE_ZERO 9'h000
`endif

// ==== common/ard_pkg.sv ====
// types for the auto-rate measurement block
package ard_pkg;
   typedef enum logic [3:0] {
      ARD_IDLE = 4'h1,
      ARD_WAIT_START = 4'h2,
      ARD_WAIT_RISE = 4'h4,
      ARD_COUNT = 4'h8
   } ard_state_type;
   typedef struct packed {
      logic wide_divisor_select;
      logic high_speed_select;
   } ard_clk_cfg_type;
   typedef struct packed {
      logic [7:0] rate_divisor_high;
      logic [7:0] rate_divisor_low;
   } ard_divisor_type;
endpackage

// ==== core/ard_rx_filter.sv ====
// three-sample majority filter for the receive line
`timescale 1ns/1ns
`default_nettype none
module ard_rx_filter
   import ard_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // line
   input wire logic rx_in,
   output logic rx_level
);
   logic [2:0] samples;
   wire logic vote;
   assign vote = (samples[0] & samples[1]) | (samples[1] & samples[2]) | (samples[0] & samples[2]);
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         samples <= 3'h7;
         rx_level <= 1'h1;
      end else if (clk_en) begin
         samples <= {samples[1:0], rx_in};
         rx_level <= vote;
      end
   end
endmodule
`default_nettype wire

// ==== verif/ard_sync_sender.sv ====
// remote sender model that puts one sync character on the line
`timescale 1ns/1ns
`default_nettype none
module ard_sync_sender #(
   parameter int BIT_CLKS = 256
) (
   // clock
   input wire logic sys_clk,
   // control and line
   input wire logic send,
   output logic rx_line
);
   logic [9:0] frame;
   initial rx_line = 1'b1;
   always @(posedge sys_clk) begin
      if (send) begin
         frame = {1'b1, 8'h55, 1'b0};
         for (int i = 0; i < 10; i++) begin
            rx_line <= frame[i];
            repeat (BIT_CLKS) @(posedge sys_clk);
         end
      end
   end
endmodule
`default_nettype wire

// ==== verif/uart_auto_baud_detect_bench.sv ====
// self-checking bench for the auto-rate measurement engine
`timescale 1ns/1ns
`default_nettype none
module uart_auto_baud_detect_bench import ard_pkg::*; ;
   localparam int BIT = 256;
   logic sys_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, rx_in, async_mode = 1'b1, wake_on_rx_enable = 1'b0;
   // strobe bits: enable set, enable clear, rollover set, rollover clear, divisor write, break, read, send
   localparam int S_EN = 0, S_CLR = 1, S_RSET = 2, S_RCLR = 3, S_DIV = 4, S_BRK = 5, S_RD = 6, S_SEND = 7;
   logic [7:0] strb = 8'h00;
   logic rate_measure_enable, measure_rollover_flag, rx_ready_flag, rx_hold_idle, rate_timer_reset;
   ard_clk_cfg_type clk_cfg = '0;
   ard_divisor_type divisor_wdata = '0, divisor;
   int miscompares = 0, n_tests = 0, n_timer = 0;
   always #25 sys_clk = ~sys_clk;
   // one-cycle pulse, so counted where it stands
   always @(posedge sys_clk) if (rate_timer_reset === 1'b1) n_timer++;
   ard_sync_sender #(.BIT_CLKS(BIT)) snd_u (.sys_clk(sys_clk), .send(strb[S_SEND]), .rx_line(rx_in));
   ard_measure dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .rx_in(rx_in),
      .async_mode(async_mode), .wake_on_rx_enable(wake_on_rx_enable), .clk_cfg(clk_cfg),
      .measure_enable_set(strb[S_EN]), .measure_enable_clear(strb[S_CLR]),
      .rollover_set(strb[S_RSET]), .rollover_clear(strb[S_RCLR]), .divisor_write(strb[S_DIV]),
      .divisor_wdata(divisor_wdata), .wake_break_done(strb[S_BRK]), .rx_holding_read(strb[S_RD]),
      .rate_measure_enable(rate_measure_enable), .measure_rollover_flag(measure_rollover_flag),
      .rx_ready_flag(rx_ready_flag), .rx_hold_idle(rx_hold_idle), .rate_timer_reset(rate_timer_reset),
      .divisor(divisor));
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic pulse(input int b);
      @(posedge sys_clk) strb <= 8'h01 << b;
      @(posedge sys_clk) strb <= 8'h00;
   endtask
   task automatic settle;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask
   task automatic measure(input logic [1:0] cfg);
      int n;
      logic [15:0] exp;
      // tick is one eighth of the configured generator clock
      exp = 8 * BIT / ((cfg == 2'b00) ? 512 : (cfg == 2'b11) ? 32 : 128);
      @(posedge sys_clk) clk_cfg <= cfg;
      pulse(S_EN);
      settle;
      chk("enable set", 1, rate_measure_enable);
      chk("divisor cleared", 0, divisor);
      pulse(S_SEND);
      repeat (BIT * 3) @(posedge sys_clk);
      #1;
      chk("rx held idle", 1, rx_hold_idle);
      n = 0;
      while (rate_measure_enable !== 1'b0 && n < 4000) begin
         @(posedge sys_clk);
         n++;
      end
      settle;
      chk("enable self clear", 0, rate_measure_enable);
      chk("rx ready", 1, rx_ready_flag);
      // prescale starts at zero on the first rise and no count is taken on the fifth rise, so one count either way
      chk("divisor period", 1, 16'(divisor >= exp - 1 && divisor <= exp + 1));
      chk("no rollover", 0, measure_rollover_flag);
      if (!cfg[1]) chk("high byte zero", 0, divisor.rate_divisor_high);
      pulse(S_RD);
      settle;
      chk("rx ready cleared", 0, rx_ready_flag);
      repeat (BIT * 2) @(posedge sys_clk);
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge sys_clk);
      miscompares++;
      $display("watchdog expired");
      complete_run();
   end
   initial begin
      repeat (3) @(posedge sys_clk);
      sys_rst <= 1'b0;
      settle;
      chk("divisor reset", 0, divisor);
      chk("flags reset", 0, {rate_measure_enable, measure_rollover_flag, rx_ready_flag, rx_hold_idle});
      @(posedge sys_clk) divisor_wdata <= 16'h1234;
      pulse(S_DIV);
      settle;
      chk("divisor write", 16'h1234, divisor);
      chk("timer reset pulses", 1, 16'(n_timer));
      pulse(S_RSET);
      settle;
      chk("rollover set", 1, measure_rollover_flag);
      pulse(S_RCLR);
      settle;
      chk("rollover clear", 0, measure_rollover_flag);
      // low clock enable must swallow a strobe
      @(posedge sys_clk) clk_en <= 1'b0;
      pulse(S_RSET);
      settle;
      chk("strobe frozen", 0, measure_rollover_flag);
      @(posedge sys_clk) clk_en <= 1'b1;
      // software clear aborts an armed measurement
      pulse(S_EN);
      pulse(S_CLR);
      settle;
      chk("enable abort", 0, {rate_measure_enable, rx_hold_idle});
      for (int k = 0; k < 4; k++) measure(2'(k));
      // synchronous mode must not measure
      @(posedge sys_clk) async_mode <= 1'b0;
      pulse(S_EN);
      pulse(S_SEND);
      repeat (BIT * 11) @(posedge sys_clk);
      #1;
      chk("no measure sync mode", 0, rx_ready_flag);
      // wake enabled: nothing until the break is done, then the next frame is measured
      @(posedge sys_clk) {async_mode, wake_on_rx_enable} <= 2'b11;
      pulse(S_SEND);
      repeat (BIT * 11) @(posedge sys_clk);
      #1;
      chk("no measure before break", 0, {rx_ready_flag, rx_hold_idle});
      pulse(S_BRK);
      settle;
      chk("divisor cleared after break", 0, divisor);
      pulse(S_SEND);
      repeat (BIT * 11) @(posedge sys_clk);
      #1;
      chk("measure after break", 16'h0001, {rate_measure_enable, rx_ready_flag});
      chk("divisor after break", 1, 16'(divisor >= 16'(8 * BIT / 32 - 1) && divisor <= 16'(8 * BIT / 32 + 1)));
      complete_run();
   end
endmodule
`default_nettype wire
